// file: hdl/irq_router_cfg.svh
`ifndef IRQ_ROUTER_CFG_SVH
`define IRQ_ROUTER_CFG_SVH

// ==========================================
// Bus geometry
`define AV_ADDR_W 8
`define AV_DATA_W 32
`define REG_DATA_W 8
`define REG_IDX_W 6

// ==========================================
// Register indices (byte address is four times the index)
`define IDX_EEPROM_CMD 6'h01
`define IDX_LINE_CONFIG 6'h04
`define IDX_IRQ_STATUS 6'h08
`define IDX_IRQ_MASK 6'h09
`define IDX_LINE_STATE 6'h0A

// ==========================================
// Field layout
`define MODE_MSB 7
`define MODE_LSB 6
`define MODE_CFG_WRITE 2'h3
`define MODE_RESET 2'h0
`define OUT_EN_BIT 7
`define SEL_MSB 6
`define SEL_LSB 4
`define OUT_EN_RESET 1'h1
`define SEL_RESET 3'h0

// ==========================================
// Event bits of the status and mask registers
`define EVT_W 3
`define EVT_REQ_RISE 0
`define EVT_CFG_REFUSED 1
`define EVT_CFG_CHANGED 2
`define EVT_RESET 3'h0
`define MASK_RESET 3'h0

`endif

// file: hdl/irq_router_pkg.sv
`include "irq_router_cfg.svh"

package irq_router_pkg;

   typedef enum logic [1:0]
   {
      MODE_NORMAL = 2'h0,
      MODE_AUTOLOAD = 2'h1,
      MODE_EEPROM_PROG = 2'h2,
      MODE_CONFIG_WRITE = 2'h3
   } op_mode_t;

   typedef struct packed
   {
      logic irq_output_enable;
      logic [2:0] irq_line_select;
   } line_cfg_t;

   typedef struct packed
   {
      logic rd;
      logic wr;
      logic [`REG_IDX_W-1:0] index;
      logic [`REG_DATA_W-1:0] wdata;
      logic lane0;
   } reg_access_t;

endpackage

// file: hdl/avalon_reg_port.sv
`timescale 1ns/1ps
`include "irq_router_cfg.svh"

module avalon_reg_port
   import irq_router_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   // Avalon-MM slave
   input wire logic [`AV_ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [`AV_DATA_W-1:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [`AV_DATA_W-1:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // Register side
   input wire logic [`REG_DATA_W-1:0] rd_value_i,
   output reg_access_t access_o,
   output logic [`REG_DATA_W-1:0] captured_o
);

   logic ack;

   // ==========================================
   // One wait cycle, then the access takes effect
   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         ack <= 1'b0;
      else
         ack <= (avs_read_i | avs_write_i) & ~ack;
   end

   assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack;

   // Read data sampled in the wait cycle, stands at the answer edge
   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         captured_o <= '0;
      else if (avs_read_i & ~ack)
         captured_o <= rd_value_i;
   end

   assign avs_readdata_o = {{(`AV_DATA_W-`REG_DATA_W){1'b0}}, captured_o};

   always_comb
   begin
      access_o.rd = avs_read_i & ack;
      access_o.wr = avs_write_i & ack;
      access_o.index = avs_address_i[`AV_ADDR_W-1:2];
      access_o.wdata = avs_writedata_i[`REG_DATA_W-1:0];
      access_o.lane0 = avs_byteenable_i[0];
   end

endmodule

// file: hdl/irq_line_driver.sv
`timescale 1ns/1ps
`include "irq_router_cfg.svh"

module irq_line_driver
   import irq_router_pkg::*;
#(
   parameter int LINES = 8
)
(
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   // Control
   input wire line_cfg_t cfg_i,
   input wire logic pending_i,
   // Interrupt lines
   output logic [LINES-1:0] line_o,
   output logic [LINES-1:0] line_oe_o
);

   // ==========================================
   // Registered line drive
   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         line_o <= '0;
         line_oe_o <= '0;
      end
      else
      begin
         for (int i = 0; i < LINES; i++)
         begin
            if (cfg_i.irq_line_select == i[2:0])
            begin
               line_o[i] <= cfg_i.irq_output_enable & pending_i;
               line_oe_o[i] <= cfg_i.irq_output_enable;
            end
            else
            begin
               line_o[i] <= 1'b0;
               line_oe_o[i] <= 1'b0;
            end
         end
      end
   end

endmodule

// file: hdl/isa_irq_line_router.sv
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "irq_router_cfg.svh"

module isa_irq_line_router
   import irq_router_pkg::*;
#(
   parameter int LINES = 8
)
(
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   // Avalon-MM slave
   input wire logic [`AV_ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [`AV_DATA_W-1:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [`AV_DATA_W-1:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // Controller side
   input wire logic irq_request_i,
   input wire logic [2:0] irq_line_select_i,
   output logic [1:0] operating_mode_selector_o,
   // Interrupt output lines
   output logic [LINES-1:0] interrupt_output_lines_o,
   output logic [LINES-1:0] interrupt_output_lines_oe_o,
   // Local interrupt
   output logic irq_o
);

   // ==========================================
   // Declarations
   reg_access_t access;
   logic [`REG_DATA_W-1:0] captured;
   logic [`REG_DATA_W-1:0] rd_value;
   op_mode_t mode;
   line_cfg_t line_cfg;
   logic out_en;
   logic [2:0] sel_q;
   logic request_q;
   logic [`EVT_W-1:0] irq_status;
   logic [`EVT_W-1:0] irq_mask;
   logic [`EVT_W-1:0] events;
   logic [`EVT_W-1:0] read_clear;
   logic cfg_write;
   logic cfg_allowed;

   // ==========================================
   // Helpers
   function automatic logic hit(input reg_access_t acc, input logic [`REG_IDX_W-1:0] idx);
      hit = acc.wr & acc.lane0 & (acc.index == idx);
   endfunction

   function automatic logic [`REG_DATA_W-1:0] pad_evt(input logic [`EVT_W-1:0] v);
      pad_evt = {{(`REG_DATA_W-`EVT_W){1'b0}}, v};
   endfunction

   // ==========================================
   // Bus slave
   avalon_reg_port u_port
   (
      .sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i),
      .avs_address_i(avs_address_i),
      .avs_read_i(avs_read_i),
      .avs_write_i(avs_write_i),
      .avs_writedata_i(avs_writedata_i),
      .avs_byteenable_i(avs_byteenable_i),
      .avs_readdata_o(avs_readdata_o),
      .avs_waitrequest_o(avs_waitrequest_o),
      .rd_value_i(rd_value),
      .access_o(access),
      .captured_o(captured)
   );

   // ==========================================
   // Operating mode selector
   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         mode <= op_mode_t'(`MODE_RESET);
      else if (hit(access, `IDX_EEPROM_CMD))
         mode <= op_mode_t'(access.wdata[`MODE_MSB:`MODE_LSB]);
   end

   assign operating_mode_selector_o = mode;

   // Config writes guarded by the mode
   assign cfg_write = hit(access, `IDX_LINE_CONFIG);
   assign cfg_allowed = (mode == op_mode_t'(`MODE_CFG_WRITE));

   // ==========================================
   // Line configuration
   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         out_en <= `OUT_EN_RESET;
      else if (cfg_write & cfg_allowed)
         out_en <= access.wdata[`OUT_EN_BIT];
   end

   // Select comes from loaded configuration, not from the bus
   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         sel_q <= `SEL_RESET;
      else
         sel_q <= irq_line_select_i;
   end

   // One driver for the whole carrier
   assign line_cfg = {out_en, sel_q};

   // ==========================================
   // Line drivers
   irq_line_driver #(.LINES(LINES)) u_drv
   (
      .sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i),
      .cfg_i(line_cfg),
      .pending_i(irq_request_i),
      .line_o(interrupt_output_lines_o),
      .line_oe_o(interrupt_output_lines_oe_o)
   );

   // ==========================================
   // Events
   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         request_q <= 1'b0;
      else
         request_q <= irq_request_i;
   end

   always_comb
   begin
      events = '0;
      events[`EVT_REQ_RISE] = irq_request_i & ~request_q;
      events[`EVT_CFG_REFUSED] = cfg_write & ~cfg_allowed;
      events[`EVT_CFG_CHANGED] = cfg_write & cfg_allowed
         & (access.wdata[`OUT_EN_BIT] != line_cfg.irq_output_enable);
   end

   // Only the bits actually returned are cleared
   assign read_clear = (access.rd && access.index == `IDX_IRQ_STATUS) ? captured[`EVT_W-1:0] : '0;

   // ==========================================
   // Sticky status, set wins over clear
   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         irq_status <= `EVT_RESET;
      else
         irq_status <= (irq_status & ~read_clear) | events;
   end

   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         irq_mask <= `MASK_RESET;
      else if (hit(access, `IDX_IRQ_MASK))
         irq_mask <= access.wdata[`EVT_W-1:0];
   end

   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         irq_o <= 1'b0;
      else
         irq_o <= |(((irq_status & ~read_clear) | events) & irq_mask);
   end

   // ==========================================
   // Read mux
   always_comb
   begin
      case (access.index)
         `IDX_EEPROM_CMD:
            rd_value = {mode, 6'h00};
         `IDX_LINE_CONFIG:
            rd_value = {line_cfg.irq_output_enable, line_cfg.irq_line_select, 4'h0};
         `IDX_IRQ_STATUS:
            rd_value = pad_evt(irq_status);
         `IDX_IRQ_MASK:
            rd_value = pad_evt(irq_mask);
         `IDX_LINE_STATE:
            rd_value = {6'h00, request_q, |interrupt_output_lines_oe_o};
         default:
            rd_value = '0;
      endcase
   end

endmodule

// file: testbench/isa_irq_line_router_monitor.sv
`timescale 1ns/1ps
module isa_irq_line_router_monitor
#(
   parameter int LINES = 8
)
(
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   // Bus
   input wire logic [7:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   input wire logic avs_waitrequest_o,
   // Controller and lines
   input wire logic irq_request_i,
   input wire logic [2:0] irq_line_select_i,
   input wire logic [1:0] operating_mode_selector_o,
   input wire logic [LINES-1:0] interrupt_output_lines_o,
   input wire logic [LINES-1:0] interrupt_output_lines_oe_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);
   logic [2:0] sel_seen;
   logic [2:0] sel_used;
   // Select as the line drive uses it, two edges behind the pin
   always_ff @(posedge sys_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         sel_seen <= 3'h0;
         sel_used <= 3'h0;
      end
      else
      begin
         sel_seen <= irq_line_select_i;
         sel_used <= sel_seen;
      end
   end
   // ==========
   // Accepted writes
   sequence s_cfg_wr;
      avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0] && avs_address_i[7:2] == 6'h04;
   endsequence
   sequence s_mode_wr;
      avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0] && avs_address_i[7:2] == 6'h01;
   endsequence
   // ==========
   // Properties
   property p_one_wait;
      (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
   endproperty
   property p_drive;
      interrupt_output_lines_oe_o[sel_used]
         |-> interrupt_output_lines_o[sel_used] == $past(irq_request_i);
   endproperty
   property p_float;
      s_cfg_wr ##0 (operating_mode_selector_o == 2'h3 && !avs_writedata_i[7])
         |-> ##[2:3] interrupt_output_lines_oe_o == '0;
   endproperty
   property p_guard;
      s_cfg_wr ##0 (operating_mode_selector_o != 2'h3 && |interrupt_output_lines_oe_o)
         |=> (|interrupt_output_lines_oe_o) [*3];
   endproperty
   property p_one_hot;
      |interrupt_output_lines_oe_o |-> interrupt_output_lines_oe_o == LINES'(1) << sel_used;
   endproperty
   property p_unsel;
      (interrupt_output_lines_oe_o & ~(LINES'(1) << sel_used)) == '0;
   endproperty
   property p_mode;
      s_mode_wr |=> operating_mode_selector_o == $past(avs_writedata_i[7:6]);
   endproperty
   a_one_wait: assert property (p_one_wait)
      else $error("wait longer than one cycle");
   a_drive: assert property (p_drive)
      else $error("selected line level wrong");
   a_float: assert property (p_float)
      else $error("line still driven after disable");
   a_guard: assert property (p_guard)
      else $error("guarded enable changed");
   a_one_hot: assert property (p_one_hot)
      else $error("driven line not the selected one");
   a_unsel: assert property (p_unsel)
      else $error("unselected line driven");
   a_mode: assert property (p_mode)
      else $error("mode bits not stored");
endmodule

bind isa_irq_line_router isa_irq_line_router_monitor #(.LINES(LINES)) mon_u (.sys_clk_i, .sys_rst_i,
   .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_waitrequest_o,
   .irq_request_i, .irq_line_select_i, .operating_mode_selector_o, .interrupt_output_lines_o,
   .interrupt_output_lines_oe_o);

// file: testbench/isa_host_model.sv
`timescale 1ns/1ps
module isa_host_model
#(
   parameter int LINES = 8
)
(
   // Clock
   input wire logic sys_clk_i,
   // Lines from the router
   input wire logic [LINES-1:0] line_i,
   input wire logic [LINES-1:0] line_oe_i,
   // Level seen by the host
   output logic [LINES-1:0] level_o
);
   logic toggle = 1'b0;
   // Released lines show a changing pattern
   always @(posedge sys_clk_i)
      toggle <= ~toggle;
   assign level_o = (line_i & line_oe_i) | ({LINES{toggle}} & ~line_oe_i);
endmodule

// file: testbench/tb_isa_irq_line_router.sv
`timescale 1ns/1ps
module tb_isa_irq_line_router;
   // ==========
   // Stimulus and observation
   logic sys_clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [7:0] avs_address_i = 8'h00;
   logic avs_read_i = 1'b0;
   logic avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = 32'h0;
   logic [3:0] avs_byteenable_i = 4'hF;
   logic irq_request_i = 1'b0;
   logic [2:0] irq_line_select_i = 3'h0;
   logic [31:0] avs_readdata_o;
   logic avs_waitrequest_o;
   logic irq_o;
   logic [1:0] operating_mode_selector_o;
   logic [7:0] lines;
   logic [7:0] oe;
   logic [7:0] level;
   logic [31:0] q;
   int n_fail = 0;
   int checked = 0;
   always #5 sys_clk_i = ~sys_clk_i;
   isa_irq_line_router dut_u (.sys_clk_i, .sys_rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
      .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .irq_request_i,
      .irq_line_select_i, .operating_mode_selector_o, .interrupt_output_lines_o(lines),
      .interrupt_output_lines_oe_o(oe), .irq_o);
   isa_host_model host_u (.sys_clk_i, .line_i(lines), .line_oe_i(oe), .level_o(level));
   // ==========
   // Tasks
   task results;
      if (n_fail == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   task bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      avs_address_i <= a;
      avs_writedata_i <= {24'h0, d};
      avs_read_i <= ~wr;
      avs_write_i <= wr;
      do
      begin
         @(posedge sys_clk_i);
         n++;
      end
      while (avs_waitrequest_o !== 1'b0 && n < 50);
      if (n >= 50)
      begin
         n_fail++;
         results();
      end
      q = avs_readdata_o;
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
      @(posedge sys_clk_i);
   endtask
   task rd(input string what, input logic [7:0] a, input logic [7:0] exp);
      bus(1'b0, a, 8'h00);
      chk(what, q, {24'h0, exp});
   endtask
   // ==========
   // Sequence
   initial
   begin
      repeat (12) @(posedge sys_clk_i);
      sys_rst_i <= 1'b0;
      @(posedge sys_clk_i);
      rd("config", 8'h10, 8'h80);
      bus(1'b1, 8'h3C, 8'hFF);
      rd("unmapped", 8'h3C, 8'h00);
      irq_request_i <= 1'b1;
      for (int s = 0; s < 8; s++)
      begin
         irq_line_select_i <= 3'(s);
         repeat (3) @(posedge sys_clk_i);
         chk("oe", {24'h0, oe}, 32'(1 << s));
         chk("level", {31'h0, level[s]}, 32'h1);
         rd("config", 8'h10, 8'h80 | 8'(s << 4));
      end
      irq_request_i <= 1'b0;
      repeat (3) @(posedge sys_clk_i);
      chk("level", {31'h0, level[7]}, 32'h0);
      chk("irq", {31'h0, irq_o}, 32'h0);
      bus(1'b1, 8'h10, 8'h00);
      rd("status", 8'h20, 8'h03);
      rd("config", 8'h10, 8'hF0);
      bus(1'b1, 8'h04, 8'hC0);
      chk("mode", {30'h0, operating_mode_selector_o}, 32'h3);
      bus(1'b1, 8'h10, 8'h7F);
      rd("config", 8'h10, 8'h70);
      chk("oe", {24'h0, oe}, 32'h0);
      bus(1'b1, 8'h24, 8'h04);
      repeat (2) @(posedge sys_clk_i);
      chk("irq", {31'h0, irq_o}, 32'h1);
      rd("mask", 8'h24, 8'h04);
      rd("status", 8'h20, 8'h04);
      repeat (2) @(posedge sys_clk_i);
      chk("irq", {31'h0, irq_o}, 32'h0);
      irq_request_i <= 1'b1;
      repeat (3) @(posedge sys_clk_i);
      chk("irq", {31'h0, irq_o}, 32'h0);
      rd("status", 8'h20, 8'h01);
      sys_rst_i <= 1'b1;
      repeat (2) @(posedge sys_clk_i);
      sys_rst_i <= 1'b0;
      @(posedge sys_clk_i);
      rd("config", 8'h10, 8'hF0);
      chk("mode", {30'h0, operating_mode_selector_o}, 32'h0);
      results();
   end
endmodule
